// ===== logic/ifb_bit_reg.sv
`timescale 1ns/10ps
// one 16-bit flag or enable register with byte-lane writes
module ifb_bit_reg
#(
   parameter logic [15:0] IMPL_MASK = 16'hffff,
   parameter bit HW_SET = 1'b1
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // software write port
   input wire logic wr_en_i,
   input wire logic [15:0] wr_data_i,
   input wire logic [1:0] wr_be_i,
   // hardware set events
   input wire logic [15:0] hw_set_i,
   // current contents
   output logic [15:0] value_o
);
   logic [15:0] value_q; // stored bits
   logic [15:0] value_d; // next value
   logic [15:0] lane; // byte-lane write mask

   // write merge; a set in the same cycle beats a software clear
   always_comb
   begin
      lane = {{8{wr_be_i[1]}}, {8{wr_be_i[0]}}};
      value_d = value_q;
      if (wr_en_i)
      begin
         value_d = (value_q & ~lane) | (wr_data_i & lane);
      end
      if (HW_SET)
      begin
         value_d = value_d | hw_set_i;
      end
      value_d = value_d & IMPL_MASK;
   end

   // storage, cleared on reset
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         value_q <= ifb_pkg::IFB_RESET_VAL;
      else
         value_q <= value_d;
   end

   assign value_o = value_q;
endmodule

// ===== logic/ifb_pkg.sv
// Behaviour
// - hardware sets flags; software reads and writes them
// - flag one means request occurred since clear
// - enable one allows request; zero blocks it
// - unimplemented bits ignore writes, read zero
// - every implemented bit resets to zero
// - flag reg 2 layout: capture 6..3, spi b
// - flag reg 3: calendar, ext 4/3, i2c b
// - flag reg 4: charge, low voltage, crc, uarts
// - flag reg 5 upper: ch9, spi c, uart d
// - flag reg 5 lower: usb, i2c c, uart c
// - enable reg 0 upper: adc, uart a, spi a, timer c
// - enable reg 0: timer b, compare 2, capture 2
package ifb_pkg;
   // register geometry
   localparam int IFB_REG_W = 16;
   localparam int IFB_ADDR_W = 8;
   // byte offsets on the register bus
   localparam logic [7:0] IFB_OFS_FLAG2 = 8'h00;
   localparam logic [7:0] IFB_OFS_FLAG3 = 8'h04;
   localparam logic [7:0] IFB_OFS_FLAG4 = 8'h08;
   localparam logic [7:0] IFB_OFS_FLAG5 = 8'h0c;
   localparam logic [7:0] IFB_OFS_EN0 = 8'h10;
   // implemented-bit masks, one per register
   localparam logic [15:0] IFB_MASK_FLAG2 = 16'h01e3;
   localparam logic [15:0] IFB_MASK_FLAG3 = 16'h4066;
   localparam logic [15:0] IFB_MASK_FLAG4 = 16'h210e;
   localparam logic [15:0] IFB_MASK_FLAG5 = 16'h3ffe;
   localparam logic [15:0] IFB_MASK_EN0 = 16'h3fef;
   // value after reset for every register
   localparam logic [15:0] IFB_RESET_VAL = 16'h0000;
   // flag register 2 fields
   localparam int CAPTURE_CH6_FLAG = 8;
   localparam int CAPTURE_CH5_FLAG = 7;
   localparam int CAPTURE_CH4_FLAG = 6;
   localparam int CAPTURE_CH3_FLAG = 5;
   localparam int SPI_B_EVENT_FLAG = 1;
   localparam int SPI_B_FAULT_FLAG = 0;
   // flag register 3 fields
   localparam int CALENDAR_CLOCK_FLAG = 14;
   localparam int EXT_IRQ4_FLAG = 6;
   localparam int EXT_IRQ3_FLAG = 5;
   localparam int I2C_B_MASTER_FLAG = 2;
   localparam int I2C_B_SLAVE_FLAG = 1;
   // flag register 4 fields
   localparam int CHARGE_TIME_MEAS_FLAG = 13;
   localparam int LOW_VOLTAGE_FLAG = 8;
   localparam int CRC_GEN_FLAG = 3;
   localparam int UART_B_ERROR_FLAG = 2;
   localparam int UART_A_ERROR_FLAG = 1;
   // flag register 5 fields
   localparam int CAPTURE_CH9_FLAG = 13;
   localparam int COMPARE_CH9_FLAG = 12;
   localparam int SPI_C_EVENT_FLAG = 11;
   localparam int SPI_C_FAULT_FLAG = 10;
   localparam int UART_D_TX_FLAG = 9;
   localparam int UART_D_RX_FLAG = 8;
   localparam int UART_D_ERROR_FLAG = 7;
   localparam int USB_OTG_FLAG = 6;
   localparam int I2C_C_MASTER_FLAG = 5;
   localparam int I2C_C_SLAVE_FLAG = 4;
   localparam int UART_C_TX_FLAG = 3;
   localparam int UART_C_RX_FLAG = 2;
   localparam int UART_C_ERROR_FLAG = 1;
   // enable register 0 fields
   localparam int ADC_DONE_ENABLE = 13;
   localparam int UART_A_TX_ENABLE = 12;
   localparam int UART_A_RX_ENABLE = 11;
   localparam int SPI_A_DONE_ENABLE = 10;
   localparam int SPI_A_FAULT_ENABLE = 9;
   localparam int TIMER_C_ENABLE = 8;
   localparam int TIMER_B_ENABLE = 7;
   localparam int COMPARE_CH2_ENABLE = 6;
   localparam int CAPTURE_CH2_ENABLE = 5;
   // bus response codes
   localparam logic [1:0] IFB_RESP_OKAY = 2'h0;
   localparam logic [1:0] IFB_RESP_SLVERR = 2'h2;
endpackage

// ===== logic/ifb_req_gate.sv
`timescale 1ns/10ps
// registered pairing of flags with their enables
module ifb_req_gate
#(
   parameter int WIDTH = 16
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // flag and enable vectors
   input wire logic [WIDTH-1:0] flag_i,
   input wire logic [WIDTH-1:0] enable_i,
   // requests towards the cpu
   output logic [WIDTH-1:0] req_o
);
   logic [WIDTH-1:0] req_q; // registered requests

   // registered so the output is glitch free
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         req_q <= '0;
      else
         req_q <= flag_i & enable_i;
   end

   assign req_o = req_q;
endmodule

// ===== logic/ifb_top.sv
`timescale 1ns/10ps
// interrupt flag and enable bank behind an axi4-lite slave
module ifb_top
(
   // clock and reset
   input wire logic REF_CLK_I,
   input wire logic RESETN_I,
   // axi4-lite write address
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [7:0] S_AXI_AWADDR_I,
   input wire logic [2:0] S_AXI_AWPROT_I,
   // axi4-lite write data
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   // axi4-lite write response
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   output logic [1:0] S_AXI_BRESP_O,
   // axi4-lite read address
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   input wire logic [7:0] S_AXI_ARADDR_I,
   input wire logic [2:0] S_AXI_ARPROT_I,
   // axi4-lite read data
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   // hardware set events, one vector per flag register
   input wire logic [15:0] FLAG2_SET_I,
   input wire logic [15:0] FLAG3_SET_I,
   input wire logic [15:0] FLAG4_SET_I,
   input wire logic [15:0] FLAG5_SET_I,
   // enables held elsewhere for flag registers 2 to 5
   input wire logic [15:0] FLAG2_EN_I,
   input wire logic [15:0] FLAG3_EN_I,
   input wire logic [15:0] FLAG4_EN_I,
   input wire logic [15:0] FLAG5_EN_I,
   // flags held elsewhere that enable register 0 gates
   input wire logic [15:0] FLAG0_I,
   // flag and enable contents
   output logic [15:0] FLAG2_O,
   output logic [15:0] FLAG3_O,
   output logic [15:0] FLAG4_O,
   output logic [15:0] FLAG5_O,
   output logic [15:0] EN0_O,
   // gated requests towards the cpu
   output logic [15:0] REQ0_O,
   output logic [15:0] REQ2_O,
   output logic [15:0] REQ3_O,
   output logic [15:0] REQ4_O,
   output logic [15:0] REQ5_O
);
   // write channel capture
   logic aw_held_q; // address taken, waiting for data
   logic [7:0] aw_addr_q; // captured write address
   logic w_held_q; // data taken, waiting for address
   logic [31:0] w_data_q; // captured write data
   logic [3:0] w_strb_q; // captured byte strobes
   // write response
   logic bvalid_q; // response pending
   logic [1:0] bresp_q; // response code
   // read channel
   logic rvalid_q; // read data pending
   logic [31:0] rdata_q; // read data
   logic [1:0] rresp_q; // read response code
   // handshake terms
   logic aw_hs; // write address taken this edge
   logic w_hs; // write data taken this edge
   logic ar_hs; // read address taken this edge
   logic do_write; // both halves present, commit now
   // write decode
   logic wr_flag2; // select flag register 2
   logic wr_flag3; // select flag register 3
   logic wr_flag4; // select flag register 4
   logic wr_flag5; // select flag register 5
   logic wr_en0; // select enable register 0
   logic wr_hit; // address maps to a register
   logic [1:0] wr_be; // low two strobes, the byte lanes of the low half
   logic [15:0] wr_val; // low half of write data
   // read decode
   logic [31:0] rd_mux; // word selected by read address
   logic rd_hit; // read address maps to a register
   // register contents
   logic [15:0] flag2; // flag register 2
   logic [15:0] flag3; // flag register 3
   logic [15:0] flag4; // flag register 4
   logic [15:0] flag5; // flag register 5
   logic [15:0] en0; // enable register 0

   // handshakes; one read in flight at most, and a second write is held while the previous response waits
   assign S_AXI_AWREADY_O = !aw_held_q;
   assign S_AXI_WREADY_O = !w_held_q;
   assign S_AXI_ARREADY_O = !rvalid_q;
   assign aw_hs = S_AXI_AWVALID_I && !aw_held_q;
   assign w_hs = S_AXI_WVALID_I && !w_held_q;
   assign ar_hs = S_AXI_ARVALID_I && !rvalid_q;
   // commit only once the previous response has gone
   assign do_write = aw_held_q && w_held_q && !bvalid_q;

   // write address capture, held until the write commits
   always_ff @(posedge REF_CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         aw_held_q <= 1'b0;
         aw_addr_q <= 8'h00;
      end
      else if (aw_hs)
      begin
         aw_held_q <= 1'b1;
         aw_addr_q <= S_AXI_AWADDR_I;
      end
      else if (do_write)
      begin
         aw_held_q <= 1'b0;
      end
   end

   // write data capture, in either order with the address
   always_ff @(posedge REF_CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         w_held_q <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end
      else if (w_hs)
      begin
         w_held_q <= 1'b1;
         w_data_q <= S_AXI_WDATA_I;
         w_strb_q <= S_AXI_WSTRB_I;
      end
      else if (do_write)
      begin
         w_held_q <= 1'b0;
      end
   end

   // write decode on the word address
   always_comb
   begin
      wr_flag2 = 1'b0;
      wr_flag3 = 1'b0;
      wr_flag4 = 1'b0;
      wr_flag5 = 1'b0;
      wr_en0 = 1'b0;
      case ({aw_addr_q[7:2], 2'b00})
         ifb_pkg::IFB_OFS_FLAG2: wr_flag2 = do_write;
         ifb_pkg::IFB_OFS_FLAG3: wr_flag3 = do_write;
         ifb_pkg::IFB_OFS_FLAG4: wr_flag4 = do_write;
         ifb_pkg::IFB_OFS_FLAG5: wr_flag5 = do_write;
         ifb_pkg::IFB_OFS_EN0: wr_en0 = do_write;
         default: wr_flag2 = 1'b0; // unmapped, no register touched
      endcase
   end

   assign wr_hit = wr_flag2 || wr_flag3 || wr_flag4 || wr_flag5 || wr_en0;
   // upper half of the word has no storage, its strobes are dropped
   assign wr_be = w_strb_q[1:0];
   assign wr_val = w_data_q[15:0];

   // write response, slverr for an address with no register
   always_ff @(posedge REF_CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         bvalid_q <= 1'b0;
         bresp_q <= ifb_pkg::IFB_RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_hit ? ifb_pkg::IFB_RESP_OKAY
                           : ifb_pkg::IFB_RESP_SLVERR;
      end
      else if (S_AXI_BREADY_I)
      begin
         bvalid_q <= 1'b0;
      end
   end

   assign S_AXI_BVALID_O = bvalid_q;
   assign S_AXI_BRESP_O = bresp_q;

   // flag register 2: capture 6..3 and spi b
   ifb_bit_reg
   #(
      .IMPL_MASK(ifb_pkg::IFB_MASK_FLAG2),
      .HW_SET(1'b1)
   )
   u_flag2
   (
      .clk_i(REF_CLK_I),
      .rst_n_i(RESETN_I),
      .wr_en_i(wr_flag2),
      .wr_data_i(wr_val),
      .wr_be_i(wr_be),
      .hw_set_i(FLAG2_SET_I),
      .value_o(flag2)
   );

   // flag register 3: calendar, external 4/3, i2c b
   ifb_bit_reg
   #(
      .IMPL_MASK(ifb_pkg::IFB_MASK_FLAG3),
      .HW_SET(1'b1)
   )
   u_flag3
   (
      .clk_i(REF_CLK_I),
      .rst_n_i(RESETN_I),
      .wr_en_i(wr_flag3),
      .wr_data_i(wr_val),
      .wr_be_i(wr_be),
      .hw_set_i(FLAG3_SET_I),
      .value_o(flag3)
   );

   // flag register 4: charge time, low voltage, crc, uart errors
   ifb_bit_reg
   #(
      .IMPL_MASK(ifb_pkg::IFB_MASK_FLAG4),
      .HW_SET(1'b1)
   )
   u_flag4
   (
      .clk_i(REF_CLK_I),
      .rst_n_i(RESETN_I),
      .wr_en_i(wr_flag4),
      .wr_data_i(wr_val),
      .wr_be_i(wr_be),
      .hw_set_i(FLAG4_SET_I),
      .value_o(flag4)
   );

   // flag register 5: bits 13 to 1 all live
   ifb_bit_reg
   #(
      .IMPL_MASK(ifb_pkg::IFB_MASK_FLAG5),
      .HW_SET(1'b1)
   )
   u_flag5
   (
      .clk_i(REF_CLK_I),
      .rst_n_i(RESETN_I),
      .wr_en_i(wr_flag5),
      .wr_data_i(wr_val),
      .wr_be_i(wr_be),
      .hw_set_i(FLAG5_SET_I),
      .value_o(flag5)
   );

   // enable register 0: software only, bit 4 has no storage
   ifb_bit_reg
   #(
      .IMPL_MASK(ifb_pkg::IFB_MASK_EN0),
      .HW_SET(1'b0)
   )
   u_en0
   (
      .clk_i(REF_CLK_I),
      .rst_n_i(RESETN_I),
      .wr_en_i(wr_en0),
      .wr_data_i(wr_val),
      .wr_be_i(wr_be),
      .hw_set_i(16'h0000),
      .value_o(en0)
   );

   // read decode; masks already keep unused bits at zero
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      case ({S_AXI_ARADDR_I[7:2], 2'b00})
         ifb_pkg::IFB_OFS_FLAG2: rd_mux = {16'h0000, flag2};
         ifb_pkg::IFB_OFS_FLAG3: rd_mux = {16'h0000, flag3};
         ifb_pkg::IFB_OFS_FLAG4: rd_mux = {16'h0000, flag4};
         ifb_pkg::IFB_OFS_FLAG5: rd_mux = {16'h0000, flag5};
         ifb_pkg::IFB_OFS_EN0: rd_mux = {16'h0000, en0};
         default: rd_hit = 1'b0; // unmapped reads zero with slverr
      endcase
   end

   // read data, captured on the address handshake
   always_ff @(posedge REF_CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= ifb_pkg::IFB_RESP_OKAY;
      end
      else if (ar_hs)
      begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux;
         rresp_q <= rd_hit ? ifb_pkg::IFB_RESP_OKAY
                           : ifb_pkg::IFB_RESP_SLVERR;
      end
      else if (S_AXI_RREADY_I)
      begin
         rvalid_q <= 1'b0;
      end
   end

   assign S_AXI_RVALID_O = rvalid_q;
   assign S_AXI_RDATA_O = rdata_q;
   assign S_AXI_RRESP_O = rresp_q;

   // enable register 0 gates the flags held outside
   ifb_req_gate
   #(
      .WIDTH(16)
   )
   u_req0
   (
      .clk_i(REF_CLK_I),
      .rst_n_i(RESETN_I),
      .flag_i(FLAG0_I),
      .enable_i(en0),
      .req_o(REQ0_O)
   );

   // local flags gated by enables held outside
   ifb_req_gate
   #(
      .WIDTH(16)
   )
   u_req2
   (
      .clk_i(REF_CLK_I),
      .rst_n_i(RESETN_I),
      .flag_i(flag2),
      .enable_i(FLAG2_EN_I),
      .req_o(REQ2_O)
   );

   ifb_req_gate
   #(
      .WIDTH(16)
   )
   u_req3
   (
      .clk_i(REF_CLK_I),
      .rst_n_i(RESETN_I),
      .flag_i(flag3),
      .enable_i(FLAG3_EN_I),
      .req_o(REQ3_O)
   );

   ifb_req_gate
   #(
      .WIDTH(16)
   )
   u_req4
   (
      .clk_i(REF_CLK_I),
      .rst_n_i(RESETN_I),
      .flag_i(flag4),
      .enable_i(FLAG4_EN_I),
      .req_o(REQ4_O)
   );

   ifb_req_gate
   #(
      .WIDTH(16)
   )
   u_req5
   (
      .clk_i(REF_CLK_I),
      .rst_n_i(RESETN_I),
      .flag_i(flag5),
      .enable_i(FLAG5_EN_I),
      .req_o(REQ5_O)
   );

   // register contents straight from the storage flops
   assign FLAG2_O = flag2;
   assign FLAG3_O = flag3;
   assign FLAG4_O = flag4;
   assign FLAG5_O = flag5;
   assign EN0_O = en0;
endmodule

// ===== verif/ifb_periph_model.sv
`timescale 1ns/10ps
// peripherals raising one-cycle event pulses into the flag bank
module ifb_periph_model
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // event order from the bench
   input wire logic fire_i,
   input wire logic [1:0] sel_i,
   input wire logic [15:0] bits_i,
   // set pulses, one vector per flag register
   output logic [15:0] set2_o,
   output logic [15:0] set3_o,
   output logic [15:0] set4_o,
   output logic [15:0] set5_o
);
   // idle lines sit low, so no stale event is repeated
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         set2_o <= 16'h0000;
         set3_o <= 16'h0000;
         set4_o <= 16'h0000;
         set5_o <= 16'h0000;
      end
      else
      begin
         // pulse lasts one cycle per event
         set2_o <= (fire_i && sel_i == 2'h0) ? bits_i : 16'h0000;
         set3_o <= (fire_i && sel_i == 2'h1) ? bits_i : 16'h0000;
         set4_o <= (fire_i && sel_i == 2'h2) ? bits_i : 16'h0000;
         set5_o <= (fire_i && sel_i == 2'h3) ? bits_i : 16'h0000;
      end
   end
endmodule

// ===== verif/ifb_top_assertions.sv
`timescale 1ns/10ps
// protocol and flag checks on the bank's ports
module ifb_top_assertions
(
   // clock and reset
   input wire logic REF_CLK_I,
   input wire logic RESETN_I,
   // bus handshakes
   input wire logic S_AXI_AWVALID_I,
   input wire logic S_AXI_AWREADY_O,
   input wire logic S_AXI_WVALID_I,
   input wire logic S_AXI_WREADY_O,
   input wire logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic [1:0] S_AXI_BRESP_O,
   input wire logic S_AXI_ARVALID_I,
   input wire logic S_AXI_ARREADY_O,
   input wire logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   input wire logic [31:0] S_AXI_RDATA_O,
   // flags, enables and requests
   input wire logic [15:0] FLAG2_SET_I,
   input wire logic [15:0] FLAG2_EN_I,
   input wire logic [15:0] FLAG0_I,
   input wire logic [15:0] FLAG2_O,
   input wire logic [15:0] EN0_O,
   input wire logic [15:0] REQ2_O,
   input wire logic [15:0] REQ0_O
);
   // implemented bits, flag register 2 and enable register 0
   localparam logic [15:0] M2 = 16'h01e3;
   localparam logic [15:0] ME = 16'h3fef;
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (!RESETN_I);
   // both halves of a write taken with no answer pending
   sequence s_wr_both;
      S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I
         && S_AXI_WREADY_O && !S_AXI_BVALID_O;
   endsequence
   // read address taken
   sequence s_rd_take;
      S_AXI_ARVALID_I && S_AXI_ARREADY_O;
   endsequence
   chk_write_answer:
   assert property (s_wr_both |-> ##2 S_AXI_BVALID_O)
      else $error("write answer missing");
   chk_read_answer:
   assert property (s_rd_take |=> S_AXI_RVALID_O)
      else $error("read answer missing");
   chk_bresp_stands:
   assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=>
      S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
      else $error("write response dropped");
   chk_rdata_stands:
   assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=>
      S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
      else $error("read data dropped");
   chk_ar_blocked:
   assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
      else $error("read address taken while busy");
   chk_upper_zero:
   assert property (S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:16] == 16'h0000)
      else $error("upper read half not zero");
   chk_unimpl_zero:
   assert property ((FLAG2_O & ~M2) == 16'h0000 && (EN0_O & ~ME) == 16'h0)
      else $error("unimplemented bit set");
   chk_hw_set:
   assert property ((FLAG2_SET_I & M2) != 16'h0000 |=>
      (FLAG2_O & $past(FLAG2_SET_I) & M2) == ($past(FLAG2_SET_I) & M2))
      else $error("hardware set lost");
   chk_req_gate:
   assert property (1'b1 |=> REQ2_O == ($past(FLAG2_O) & $past(FLAG2_EN_I)))
      else $error("request not flag and enable");
   chk_req0_gate:
   assert property (1'b1 |=> REQ0_O == ($past(FLAG0_I) & $past(EN0_O)))
      else $error("request zero not gated");
   chk_no_spurious:
   assert property (1'b1 |=> $rose(S_AXI_BVALID_O) ||
      (FLAG2_O & ~$past(FLAG2_O) & ~$past(FLAG2_SET_I)) == 16'h0000)
      else $error("flag rose without cause");
endmodule
bind ifb_top ifb_top_assertions u_chk
(
   .REF_CLK_I, .RESETN_I, .S_AXI_AWVALID_I, .S_AXI_AWREADY_O,
   .S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I,
   .S_AXI_BRESP_O, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RVALID_O,
   .S_AXI_RREADY_I, .S_AXI_RDATA_O, .FLAG2_SET_I, .FLAG2_EN_I, .FLAG0_I,
   .FLAG2_O, .EN0_O, .REQ2_O, .REQ0_O
);

// ===== verif/tb_irq_flag_enable_bank.sv
`timescale 1ns/10ps
// self-checking bench for the flag and enable bank
module tb_irq_flag_enable_bank;
   // bench-driven design inputs
   logic REF_CLK_I = 1'b0, RESETN_I = 1'b0;
   logic S_AXI_AWVALID_I = 1'b0, S_AXI_WVALID_I = 1'b0;
   logic S_AXI_BREADY_I = 1'b0, S_AXI_ARVALID_I = 1'b0;
   logic S_AXI_RREADY_I = 1'b0;
   logic [7:0] S_AXI_AWADDR_I = 8'h00, S_AXI_ARADDR_I = 8'h00;
   logic [31:0] S_AXI_WDATA_I = 32'h0;
   logic [3:0] S_AXI_WSTRB_I = 4'hf;
   logic [15:0] FLAG2_EN_I = 16'h0, FLAG3_EN_I = 16'h0;
   logic [15:0] FLAG4_EN_I = 16'h0, FLAG5_EN_I = 16'h0;
   logic [15:0] FLAG0_I = 16'h0, bits = 16'h0;
   logic fire = 1'b0;
   logic [1:0] sel = 2'h0;
   // design outputs and model pulses
   logic S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O;
   logic S_AXI_ARREADY_O, S_AXI_RVALID_O;
   logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O;
   logic [31:0] S_AXI_RDATA_O;
   logic [15:0] FLAG2_SET_I, FLAG3_SET_I, FLAG4_SET_I, FLAG5_SET_I;
   logic [15:0] REQ0_O, REQ2_O, REQ3_O, REQ4_O, REQ5_O;
   logic [15:0] FLAG2_O, FLAG3_O, FLAG4_O, FLAG5_O, EN0_O;
   int err_count = 0, checked = 0;
   // implemented bits per register, flags 2..5 then enable 0
   logic [15:0] msk [5] = '{16'h01e3, 16'h4066, 16'h210e, 16'h3ffe,
      16'h3fef};
   logic [7:0] ofs [5] = '{ifb_pkg::IFB_OFS_FLAG2, ifb_pkg::IFB_OFS_FLAG3,
      ifb_pkg::IFB_OFS_FLAG4, ifb_pkg::IFB_OFS_FLAG5, ifb_pkg::IFB_OFS_EN0};

   always #50 REF_CLK_I = ~REF_CLK_I;

   // protection fields tied; strobes driven for the lane test
   ifb_top uut
   (
      .REF_CLK_I, .RESETN_I, .S_AXI_AWVALID_I, .S_AXI_AWREADY_O,
      .S_AXI_AWADDR_I, .S_AXI_AWPROT_I(3'h0), .S_AXI_WVALID_I,
      .S_AXI_WREADY_O, .S_AXI_WDATA_I, .S_AXI_WSTRB_I,
      .S_AXI_BVALID_O, .S_AXI_BREADY_I, .S_AXI_BRESP_O, .S_AXI_ARVALID_I,
      .S_AXI_ARREADY_O, .S_AXI_ARADDR_I, .S_AXI_ARPROT_I(3'h0),
      .S_AXI_RVALID_O, .S_AXI_RREADY_I, .S_AXI_RDATA_O, .S_AXI_RRESP_O,
      .FLAG2_SET_I, .FLAG3_SET_I, .FLAG4_SET_I, .FLAG5_SET_I, .FLAG2_EN_I,
      .FLAG3_EN_I, .FLAG4_EN_I, .FLAG5_EN_I, .FLAG0_I, .FLAG2_O,
      .FLAG3_O, .FLAG4_O, .FLAG5_O, .EN0_O, .REQ0_O, .REQ2_O,
      .REQ3_O, .REQ4_O, .REQ5_O
   );

   ifb_periph_model u_model
   (
      .clk_i(REF_CLK_I), .rst_n_i(RESETN_I), .fire_i(fire), .sel_i(sel),
      .bits_i(bits), .set2_o(FLAG2_SET_I), .set3_o(FLAG3_SET_I),
      .set4_o(FLAG4_SET_I), .set5_o(FLAG5_SET_I)
   );

   // compare and count
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // verdict and end of run
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // one write; response accepted late to exercise the stall
   task automatic axi_wr(input logic [7:0] a, input logic [15:0] v,
      output logic [1:0] r);
      S_AXI_AWADDR_I <= a;
      S_AXI_WDATA_I <= {16'h0000, v};
      S_AXI_AWVALID_I <= 1'b1;
      S_AXI_WVALID_I <= 1'b1;
      do
      begin
         @(posedge REF_CLK_I);
         if (S_AXI_AWREADY_O)
            S_AXI_AWVALID_I <= 1'b0;
         if (S_AXI_WREADY_O)
            S_AXI_WVALID_I <= 1'b0;
      end
      while ((S_AXI_AWVALID_I && !S_AXI_AWREADY_O) ||
         (S_AXI_WVALID_I && !S_AXI_WREADY_O));
      while (!S_AXI_BVALID_O) @(posedge REF_CLK_I);
      S_AXI_BREADY_I <= 1'b1;
      @(posedge REF_CLK_I);
      r = S_AXI_BRESP_O;
      S_AXI_BREADY_I <= 1'b0;
   endtask

   // one read; data accepted late to exercise the stall
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      S_AXI_ARADDR_I <= a;
      S_AXI_ARVALID_I <= 1'b1;
      do @(posedge REF_CLK_I); while (!S_AXI_ARREADY_O);
      S_AXI_ARVALID_I <= 1'b0;
      while (!S_AXI_RVALID_O) @(posedge REF_CLK_I);
      S_AXI_RREADY_I <= 1'b1;
      @(posedge REF_CLK_I);
      d = S_AXI_RDATA_O;
      r = S_AXI_RRESP_O;
      S_AXI_RREADY_I <= 1'b0;
   endtask

   // main sequence
   initial
   begin
      logic [31:0] d;
      logic [1:0] r;
      logic [15:0] w;
      void'($urandom(32'h3251));
      repeat (5) @(posedge REF_CLK_I);
      RESETN_I <= 1'b1;
      @(posedge REF_CLK_I);
      for (int i = 0; i < 5; i++)
      begin
         axi_rd(ofs[i], d, r);
         check(d, 32'h0);
      end
      $display("test reset values done");
      // all ones: only implemented bits stick
      for (int i = 0; i < 5; i++)
      begin
         axi_wr(ofs[i], 16'hffff, r);
         check(r, ifb_pkg::IFB_RESP_OKAY);
         axi_rd(ofs[i], d, r);
         check(d, {16'h0, msk[i]});
      end
      // content outputs must agree with what the bus reads back
      check(FLAG2_O, msk[0]);
      check(FLAG3_O, msk[1]);
      check(FLAG4_O, msk[2]);
      check(FLAG5_O, msk[3]);
      check(EN0_O, msk[4]);
      FLAG2_EN_I <= 16'($urandom);
      FLAG3_EN_I <= 16'($urandom);
      FLAG4_EN_I <= 16'($urandom);
      FLAG5_EN_I <= 16'($urandom);
      FLAG0_I <= 16'($urandom);
      repeat (3) @(posedge REF_CLK_I);
      check(REQ2_O, msk[0] & FLAG2_EN_I);
      check(REQ3_O, msk[1] & FLAG3_EN_I);
      check(REQ4_O, msk[2] & FLAG4_EN_I);
      check(REQ5_O, msk[3] & FLAG5_EN_I);
      check(REQ0_O, msk[4] & FLAG0_I);
      $display("test layout and gating done");
      // software write, then a hardware event on top of it
      for (int i = 0; i < 4; i++)
      begin
         w = 16'($urandom);
         axi_wr(ofs[i], w, r);
         bits <= 16'($urandom);
         sel <= 2'(i);
         fire <= 1'b1;
         @(posedge REF_CLK_I);
         fire <= 1'b0;
         repeat (2) @(posedge REF_CLK_I);
         axi_rd(ofs[i], d, r);
         check(d, {16'h0, (w | bits) & msk[i]});
         axi_wr(ofs[i], 16'h0000, r);
         axi_rd(ofs[i], d, r);
         check(d, 32'h0);
      end
      repeat (2) @(posedge REF_CLK_I);
      check(REQ2_O, 16'h0000);
      $display("test events and clearing done");
      // upper byte lane only; flag 5 was cleared above
      S_AXI_WSTRB_I <= 4'h2;
      axi_wr(ofs[3], 16'hffff, r);
      S_AXI_WSTRB_I <= 4'hf;
      axi_rd(ofs[3], d, r);
      check(d, {16'h0, msk[3] & 16'hff00});
      $display("test byte lanes done");
      // unmapped address refused
      axi_wr(8'h14, 16'hffff, r);
      check(r, ifb_pkg::IFB_RESP_SLVERR);
      axi_rd(8'h14, d, r);
      check(d, 32'h0);
      check(r, ifb_pkg::IFB_RESP_SLVERR);
      $display("test unmapped done");
      end_sim;
   end

   // watchdog: the run needs well under 1000 cycles
   initial
   begin
      repeat (5000) @(posedge REF_CLK_I);
      err_count++;
      $display("MISMATCH %0t watchdog expired", $time);
      end_sim;
   end
endmodule
